// ==== verilog/cic_core.sv ====
// Function
// (RL1) Interrupt control mirrored at four bank addresses
// (RL2) Bit 5 enables timer zero overflow request
// (RL3) Bit 4 enables external pin interrupt
// (RL4) Bit 3 enables port B change interrupt
// (RL5) Per-pin enable qualifies port B change detection
// (RL6) Bit 6 gates all peripheral sources
// (RL7) Each peripheral flag gated by own enable
// (RL8) Flags set regardless of any enable; the port B flag here still needs its per-pin enable
// (RL9) Edge select picks rising or falling pin edge
// (RL10) Global bit 7 gates request; flags sticky
`timescale 1ns/1ps
`default_nettype none

module cic_core (
    // Clock, reset and register bus
    input  wire  logic                  CLK_IN,
    input  wire  logic                  RST_N_IN,
    input  wire  cic_pkg::cic_apb_req_t APB_REQ_IN,
    output var   cic_pkg::cic_apb_rsp_t APB_RSP_OUT,
    // Event sources
    input  wire  logic                  TIMER_ZERO_OVF_IN,
    input  wire  logic                  EXTERNAL_IRQ_PIN_IN,
    input  wire  logic [7:0]            PORTB_PINS_IN,
    input  wire  logic [7:0]            PERIPH_FLAGS_IN,
    // Requests to the core
    output logic                        CPU_IRQ_OUT,
    output logic                        IRQ_OUT
);
    import cic_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************

    typedef struct packed {
        // Software-visible registers
        logic [7:0]       irq_ctrl;
        logic [7:0]       pin_chg_en;
        logic [7:0]       periph_en;
        logic             ext_edge_select;
        logic [3:0]       evt_status;
        logic [3:0]       evt_mask;
        // Pin synchronisers and last agreed levels
        logic [2:0]       ext_sync;
        logic             ext_level;
        logic [2:0][7:0]  pb_sync;
        logic [7:0]       pb_level;
        // Registered outputs and read data
        logic             cpu_req;
        logic             irq;
        logic [31:0]      prdata;
    } cic_state_t;

    // Current copy and the copy for the next edge
    cic_state_t state;
    cic_state_t next_state;

    // ****************************************************************
    // Address decode
    // ****************************************************************

    // Any of the four bank copies of the control register
    function automatic logic is_irq_ctrl_idx(input logic [9:0] idx);
        is_irq_ctrl_idx = (idx == IRQ_CTRL_IDX_BANK0) ||
                          (idx == IRQ_CTRL_IDX_BANK1) ||
                          (idx == IRQ_CTRL_IDX_BANK2) ||
                          (idx == IRQ_CTRL_IDX_BANK3); // [RL1]
    endfunction

    // Shared by the read and write paths so both see the same map
    function automatic cic_sel_t decode_addr(input logic [11:0] addr);
        logic [9:0] idx;
        idx = addr[11:2];
        decode_addr = CIC_SEL_NONE;
        // Misaligned byte addresses reach no register
        if (addr[1:0] == 2'h0) begin
            // All four banks land on one physical register
            if (is_irq_ctrl_idx(idx)) begin
                decode_addr = CIC_SEL_IRQ_CTRL; // [RL1]
            end else if (idx == CONFIG_IDX) begin
                decode_addr = CIC_SEL_CONFIG;
            end else if (idx == PIN_CHG_EN_IDX) begin
                decode_addr = CIC_SEL_PCE;
            end else if (idx == PERIPH_EN_IDX) begin
                decode_addr = CIC_SEL_PIE;
            end else if (idx == EVT_STATUS_IDX) begin
                decode_addr = CIC_SEL_STATUS;
            end else if (idx == EVT_MASK_IDX) begin
                decode_addr = CIC_SEL_MASK;
            end
        end
    endfunction

    // ****************************************************************
    // Bus handshake
    // ****************************************************************

    // Decoded request qualifiers
    cic_sel_t   sel;
    logic       access;
    logic       setup_rd;
    logic       wr_en;

    // Zero wait states: every access phase completes at once
    // so pready is never held low
    assign sel      = decode_addr(APB_REQ_IN.paddr);
    assign access   = APB_REQ_IN.psel & APB_REQ_IN.penable;
    assign setup_rd = APB_REQ_IN.psel & ~APB_REQ_IN.penable & ~APB_REQ_IN.pwrite;
    assign wr_en    = access & APB_REQ_IN.pwrite;

    // One assignment, so the answer struct has a single driver
    // pslverr marks unmapped or misaligned words
    assign APB_RSP_OUT = '{
        pready:  access,
        pslverr: access & (sel == CIC_SEL_NONE),
        prdata:  state.prdata
    };

    // ****************************************************************
    // Source events
    // ****************************************************************

    // Event and request terms
    logic        ext_agree;
    logic        ext_edge;
    logic [7:0]  pb_agree;
    logic [7:0]  pb_change;
    logic        tmr_evt;
    logic        ext_evt;
    logic        pb_evt;
    logic        periph_req;
    logic        src_req;
    logic        tmr_req;
    logic        ext_req;
    logic        pb_req;

    // ****************************************************************
    // Synchronisers
    // ****************************************************************

    // Pin levels count only once stages two and three agree
    assign ext_agree = (state.ext_sync[1] == state.ext_sync[2]);
    assign pb_agree  = ~(state.pb_sync[1] ^ state.pb_sync[2]);

    // ****************************************************************
    // Event detection
    // ****************************************************************

    // Edge polarity follows the configured select
    // Level starts low, so a pin high at reset gives one edge
    assign ext_edge = ext_agree & (state.ext_sync[2] != state.ext_level) &
                      (state.ext_sync[2] == state.ext_edge_select); // [RL9]

    // Only enabled pins may raise the port change flag
    assign pb_change = pb_agree & (state.pb_sync[2] ^ state.pb_level) &
                       state.pin_chg_en; // [RL5]

    // Flags rise on their conditions with no regard to the control enables; port B still needs a pin enable
    // The timer pulse is already on this clock
    assign tmr_evt = TIMER_ZERO_OVF_IN; // [RL8]
    assign ext_evt = ext_edge;          // [RL8]
    assign pb_evt  = |pb_change;        // [RL8]

    // ****************************************************************
    // Request terms
    // ****************************************************************

    // Peripheral flags gated one by one, then by the group bit
    assign periph_req = state.irq_ctrl[PERIPH_GROUP_ENABLE_BIT] &        // [RL6]
                        (|(PERIPH_FLAGS_IN & state.periph_en));          // [RL7]

    // Each source asks only while its own enable is set
    assign tmr_req = state.irq_ctrl[TIMER_ZERO_OVF_ENABLE_BIT] &
                     state.irq_ctrl[TIMER_ZERO_OVF_FLAG_BIT];            // [RL2]
    assign ext_req = state.irq_ctrl[EXT_PIN_IRQ_ENABLE_BIT] &
                     state.irq_ctrl[EXT_PIN_IRQ_FLAG_BIT];               // [RL3]
    assign pb_req  = state.irq_ctrl[PORTB_CHANGE_ENABLE_BIT] &
                     state.irq_ctrl[PORTB_CHANGE_FLAG_BIT];              // [RL4]

    // Combined unmasked sources before the global gate
    assign src_req = tmr_req | ext_req | pb_req | periph_req;

    // ****************************************************************
    // Next state
    // ****************************************************************

    always_comb begin
        logic [7:0] wdata;
        logic [3:0] evts;
        wdata = APB_REQ_IN.pwdata[7:0];
        evts  = 4'h0;
        // Every field holds unless changed below
        next_state = state;

        // Three-stage synchronisers; the first stage feeds only the second
        next_state.ext_sync = {state.ext_sync[1:0], EXTERNAL_IRQ_PIN_IN};
        next_state.pb_sync  = {state.pb_sync[1:0], PORTB_PINS_IN};
        // Levels move only when stages two and three agree
        if (ext_agree) begin
            next_state.ext_level = state.ext_sync[2];
        end
        for (int i = 0; i < 8; i++) begin
            if (pb_agree[i]) begin
                next_state.pb_level[i] = state.pb_sync[2][i];
            end
        end

        // Software writes; control flags are cleared by writing zero, status bits by writing one
        if (wr_en) begin
            unique case (sel)
                // Whole byte written; a zero clears a flag
                CIC_SEL_IRQ_CTRL: begin
                    next_state.irq_ctrl = wdata; // [RL1] [RL10]
                end

                // Edge select lives alone in bit 0
                CIC_SEL_CONFIG: begin
                    next_state.ext_edge_select = wdata[EXT_EDGE_SELECT_BIT];
                end

                // Per-pin change enables
                CIC_SEL_PCE: begin
                    next_state.pin_chg_en = wdata;
                end

                // Peripheral enables
                CIC_SEL_PIE: begin
                    next_state.periph_en = wdata;
                end

                // Write one to clear; zeros leave bits alone
                CIC_SEL_STATUS: begin
                    next_state.evt_status = state.evt_status & ~wdata[3:0];
                end

                // Mask for the level output
                CIC_SEL_MASK: begin
                    next_state.evt_mask = wdata[3:0];
                end

                // Unmapped words get an error and are dropped
                CIC_SEL_NONE: begin
                    next_state.irq_ctrl = state.irq_ctrl;
                end
            endcase
        end

        // Hardware sets after the write so a same-cycle event is never lost
        // The set therefore wins over a clearing write
        if (tmr_evt) begin
            next_state.irq_ctrl[TIMER_ZERO_OVF_FLAG_BIT] = 1'b1; // [RL8] [RL10]
        end

        if (ext_evt) begin
            next_state.irq_ctrl[EXT_PIN_IRQ_FLAG_BIT] = 1'b1; // [RL8] [RL10]
        end

        if (pb_evt) begin
            next_state.irq_ctrl[PORTB_CHANGE_FLAG_BIT] = 1'b1; // [RL8] [RL10]
        end

        // Request to the core only while the global bit is set
        // Registered, so the core sees it one cycle after the flag
        next_state.cpu_req = state.irq_ctrl[GLOBAL_IRQ_ENABLE_BIT] & src_req; // [RL10]

        // Sticky event log for the level interrupt output
        evts[EVT_TIMER_BIT]   = tmr_evt;
        evts[EVT_EXT_PIN_BIT] = ext_evt;
        evts[EVT_PORTB_BIT]   = pb_evt;
        // Bit 3 logs a rising edge of the core request
        evts[EVT_CPU_REQ_BIT] = next_state.cpu_req & ~state.cpu_req;
        next_state.evt_status = next_state.evt_status | evts;
        // Level output trails status and mask by one cycle
        next_state.irq = |(state.evt_status & state.evt_mask);

        // Read data is latched in the setup phase
        // and stands until the next read setup
        if (setup_rd) begin
            next_state.prdata = 32'h0000_0000;
            unique case (sel)
                CIC_SEL_IRQ_CTRL: begin
                    next_state.prdata[7:0] = state.irq_ctrl; // [RL1]
                end

                CIC_SEL_CONFIG: begin
                    next_state.prdata[EXT_EDGE_SELECT_BIT] = state.ext_edge_select;
                end

                CIC_SEL_PCE: begin
                    next_state.prdata[7:0] = state.pin_chg_en;
                end

                CIC_SEL_PIE: begin
                    next_state.prdata[7:0] = state.periph_en;
                end

                CIC_SEL_STATUS: begin
                    next_state.prdata[3:0] = state.evt_status;
                end

                CIC_SEL_MASK: begin
                    next_state.prdata[3:0] = state.evt_mask;
                end

                CIC_SEL_NONE: begin
                    next_state.prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Synchronous reset; every field takes a constant
    // Synchronisers clear too, so pins held high look like an edge
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            // Registers as software first sees them
            state.irq_ctrl        <= INTERRUPT_CONTROL_RST;
            state.pin_chg_en      <= PIN_CHG_EN_RST;
            state.periph_en       <= PERIPH_EN_RST;
            state.ext_edge_select <= EXT_EDGE_SELECT_RST;
            state.evt_status      <= EVT_STATUS_RST;
            state.evt_mask        <= EVT_MASK_RST;

            // Pin history
            state.ext_sync        <= SYNC_RST;
            state.ext_level       <= 1'b0;
            state.pb_sync         <= '0;
            state.pb_level        <= 8'h00;

            // Outputs and read data quiet
            state.cpu_req         <= 1'b0;
            state.irq             <= 1'b0;
            state.prdata          <= 32'h0000_0000;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Registered request outputs
    assign CPU_IRQ_OUT = state.cpu_req;
    assign IRQ_OUT     = state.irq;

endmodule
`default_nettype wire

// ==== verilog/cic_pkg.sv ====
`default_nettype none
// ****************************************************************
// Package for the core interrupt control block
// ****************************************************************
package cic_pkg;

    // Register indexes; the APB byte address is four times the index
    localparam logic [9:0] IRQ_CTRL_IDX_BANK0 = 10'h00B;
    localparam logic [9:0] IRQ_CTRL_IDX_BANK1 = 10'h08B;
    localparam logic [9:0] IRQ_CTRL_IDX_BANK2 = 10'h10B;
    localparam logic [9:0] IRQ_CTRL_IDX_BANK3 = 10'h18B;
    localparam logic [9:0] CONFIG_IDX       = 10'h1C0;
    localparam logic [9:0] PIN_CHG_EN_IDX   = 10'h1C1;
    localparam logic [9:0] PERIPH_EN_IDX    = 10'h1C2;
    localparam logic [9:0] EVT_STATUS_IDX   = 10'h1C3;
    localparam logic [9:0] EVT_MASK_IDX     = 10'h1C4;

    // Field positions in interrupt_control
    localparam int GLOBAL_IRQ_ENABLE_BIT     = 7;
    localparam int PERIPH_GROUP_ENABLE_BIT   = 6;
    localparam int TIMER_ZERO_OVF_ENABLE_BIT = 5;
    localparam int EXT_PIN_IRQ_ENABLE_BIT    = 4;
    localparam int PORTB_CHANGE_ENABLE_BIT   = 3;
    localparam int TIMER_ZERO_OVF_FLAG_BIT   = 2;
    localparam int EXT_PIN_IRQ_FLAG_BIT      = 1;
    localparam int PORTB_CHANGE_FLAG_BIT     = 0;

    // Field positions in the configuration and event registers
    localparam int EXT_EDGE_SELECT_BIT = 0;
    localparam int EVT_TIMER_BIT       = 0;
    localparam int EVT_EXT_PIN_BIT     = 1;
    localparam int EVT_PORTB_BIT       = 2;
    localparam int EVT_CPU_REQ_BIT     = 3;

    // Values after reset
    localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
    localparam logic [7:0] PIN_CHG_EN_RST        = 8'h00;
    localparam logic [7:0] PERIPH_EN_RST         = 8'h00;
    localparam logic       EXT_EDGE_SELECT_RST   = 1'h1;
    localparam logic [3:0] EVT_STATUS_RST        = 4'h0;
    localparam logic [3:0] EVT_MASK_RST          = 4'h0;
    localparam logic [2:0] SYNC_RST              = 3'h0;

    // Register selected by an APB address
    typedef enum logic [2:0] {
        CIC_SEL_NONE   = 3'b000,
        CIC_SEL_IRQ_CTRL = 3'b001,
        CIC_SEL_CONFIG = 3'b010,
        CIC_SEL_PCE    = 3'b011,
        CIC_SEL_PIE    = 3'b100,
        CIC_SEL_STATUS = 3'b101,
        CIC_SEL_MASK   = 3'b110
    } cic_sel_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cic_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } cic_apb_rsp_t;

endpackage
`default_nettype wire

// ==== verification/cic_core_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port-level checker for the control block
// ****************************************
module cic_core_sva (
    input wire logic                  CLK_IN,
    input wire logic                  RST_N_IN,
    input wire cic_pkg::cic_apb_req_t APB_REQ_IN,
    input wire cic_pkg::cic_apb_rsp_t APB_RSP_OUT,
    input wire logic                  TIMER_ZERO_OVF_IN,
    input wire logic [7:0]            PERIPH_FLAGS_IN,
    input wire logic                  CPU_IRQ_OUT,
    input wire logic                  IRQ_OUT
);
    import cic_pkg::*;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    logic       acc, wr, hit_ic, mapped, global_irq_enable, ten, msk;
    logic [9:0] idx;
    // Address decode seen from the bus alone
    assign idx = APB_REQ_IN.paddr[11:2];
    assign acc = APB_REQ_IN.psel && APB_REQ_IN.penable;
    assign wr = acc && APB_REQ_IN.pwrite;
    assign hit_ic = idx inside {IRQ_CTRL_IDX_BANK0, IRQ_CTRL_IDX_BANK1,
                                IRQ_CTRL_IDX_BANK2, IRQ_CTRL_IDX_BANK3};
    assign mapped = (APB_REQ_IN.paddr[1:0] == 2'h0) && (hit_ic || idx inside {[CONFIG_IDX:EVT_MASK_IDX]});
    // Shadow of enables; kept from writes only, flags are not needed
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            global_irq_enable <= 1'b0;
            ten <= 1'b0;
            msk <= 1'b0;
        end else if (wr && mapped && hit_ic) begin
            global_irq_enable <= APB_REQ_IN.pwdata[7];
            ten <= APB_REQ_IN.pwdata[5];
        end else if (wr && mapped && idx == EVT_MASK_IDX) begin
            msk <= |APB_REQ_IN.pwdata[3:0];
        end
    end
    property p_ready; APB_RSP_OUT.pready == acc; endproperty
    a_ready: assert property (p_ready) else $error("pready not tied to access phase");
    property p_err; acc |-> APB_RSP_OUT.pslverr == !mapped; endproperty
    a_err: assert property (p_err) else $error("pslverr wrong for address");
    property p_quiet; disable iff (1'b0) !RST_N_IN |=> !CPU_IRQ_OUT && !IRQ_OUT; endproperty
    a_quiet: assert property (p_quiet) else $error("request during reset");
    property p_global; CPU_IRQ_OUT |-> $past(global_irq_enable); endproperty
    a_global: assert property (p_global) else $error("request with global enable off");
    property p_timer; TIMER_ZERO_OVF_IN && global_irq_enable && ten && !wr ##1 !wr |-> ##1 CPU_IRQ_OUT; endproperty
    a_timer: assert property (p_timer) else $error("timer overflow gave no request");
    property p_hold; CPU_IRQ_OUT && !$past(wr) && $stable(PERIPH_FLAGS_IN) |=> CPU_IRQ_OUT; endproperty
    a_hold: assert property (p_hold) else $error("request dropped without a write");
    property p_mask; IRQ_OUT |-> $past(msk); endproperty
    a_mask: assert property (p_mask) else $error("event line high with mask clear");
    property p_rdhold; !(APB_REQ_IN.psel && !APB_REQ_IN.penable && !APB_REQ_IN.pwrite) |=> $stable(APB_RSP_OUT.prdata); endproperty
    a_rdhold: assert property (p_rdhold) else $error("read data moved outside read setup");
    c_irq: cover property (CPU_IRQ_OUT);
    c_evt: cover property (IRQ_OUT);
    c_err: cover property (acc && APB_RSP_OUT.pslverr);
endmodule
bind cic_core cic_core_sva u_sva (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .APB_REQ_IN(APB_REQ_IN),
    .APB_RSP_OUT(APB_RSP_OUT), .TIMER_ZERO_OVF_IN(TIMER_ZERO_OVF_IN), .PERIPH_FLAGS_IN(PERIPH_FLAGS_IN),
    .CPU_IRQ_OUT(CPU_IRQ_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// ==== verification/cic_periph_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ******************************************
// Event sources: timer, pins and peripherals
// ******************************************
module cic_periph_model (
    input  wire logic       CLK_IN,
    input  wire logic       tick_in,
    input  wire logic       ext_in,
    input  wire logic [7:0] pb_in,
    input  wire logic [7:0] pf_in,
    output logic            timer_out = 1'b0,
    output logic            ext_out = 1'b0,
    output logic [7:0]      pb_out = 8'h00,
    output logic [7:0]      pf_out = 8'h00
);
    logic tick_q = 1'b0;
    // Overflow is a single-cycle pulse, however long the request level stays up
    always @(posedge CLK_IN) begin
        tick_q <= tick_in;
        timer_out <= tick_in && !tick_q;
        ext_out <= ext_in;
        pb_out <= pb_in;
        pf_out <= pf_in;
    end
endmodule
`default_nettype wire

// ==== verification/cic_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ***********************
// Control block testbench
// ***********************
module cic_core_tb;
    import cic_pkg::*;
    typedef struct {logic [11:0] wa; logic [11:0] ra; logic [31:0] wd; logic [31:0] ex;} cic_row_t;
    localparam logic [11:0] B0 = {IRQ_CTRL_IDX_BANK0, 2'h0};
    localparam logic [11:0] B1 = {IRQ_CTRL_IDX_BANK1, 2'h0};
    localparam logic [11:0] B2 = {IRQ_CTRL_IDX_BANK2, 2'h0};
    localparam logic [11:0] B3 = {IRQ_CTRL_IDX_BANK3, 2'h0};
    localparam logic [11:0] CFG = {CONFIG_IDX, 2'h0};
    localparam logic [11:0] PCE = {PIN_CHG_EN_IDX, 2'h0};
    localparam logic [11:0] PIE = {PERIPH_EN_IDX, 2'h0};
    localparam logic [11:0] STS = {EVT_STATUS_IDX, 2'h0};
    localparam logic [11:0] MSK = {EVT_MASK_IDX, 2'h0};
    logic         clk = 1'b0, rst_n = 1'b0, tick = 1'b0, ext = 1'b0;
    logic [7:0]   pb = 8'h00, pf = 8'h00, pb_pin, pf_pin;
    logic         tmr, ext_pin, cpu_irq, irq, er;
    logic [31:0]  rd;
    cic_apb_req_t req = '0;
    cic_apb_rsp_t rsp;
    int           fail_count = 0, cmp_count = 0;
    // Mirror rows: written at one bank, read back at another; upper bits must vanish
    cic_row_t rows [4] = '{'{B0, B3, 32'h123456A5, 32'h000000A5}, '{B1, B2, 32'hFFFFFF5A, 32'h0000005A},
                           '{B2, B0, 32'h000000FF, 32'h000000FF}, '{B3, B1, 32'hFFFFFF00, 32'h00000000}};
    always #50 clk = ~clk;
    cic_periph_model SRC (.CLK_IN(clk), .tick_in(tick), .ext_in(ext), .pb_in(pb), .pf_in(pf),
        .timer_out(tmr), .ext_out(ext_pin), .pb_out(pb_pin), .pf_out(pf_pin));
    cic_core DUT (.CLK_IN(clk), .RST_N_IN(rst_n), .APB_REQ_IN(req), .APB_RSP_OUT(rsp), .TIMER_ZERO_OVF_IN(tmr),
        .EXTERNAL_IRQ_PIN_IN(ext_pin), .PORTB_PINS_IN(pb_pin), .PERIPH_FLAGS_IN(pf_pin),
        .CPU_IRQ_OUT(cpu_irq), .IRQ_OUT(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request holds until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1) @(posedge clk);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Outputs are looked at mid-cycle, well away from the launching edge
    task automatic look(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic pulse;
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        print_verdict;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(B0, 32'h0);
        rdchk(CFG, 32'h1);
        look(0);
        chk(cpu_irq, 1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].wa, rows[i].wd);
            rdchk(rows[i].ra, rows[i].ex);
        end
        apb(1'b0, 12'h004, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, B0 + 12'h1, 32'hFF);
        chk(er, 1'b1);
        rdchk(B0, 32'h0);
        $display("test mirror done");
        pulse;
        rdchk(B0, 32'h04);
        look(0);
        chk(cpu_irq, 1'b0);
        apb(1'b1, B1, 32'hA4);
        look(2);
        chk(cpu_irq, 1'b1);
        apb(1'b1, B2, 32'h24);
        look(2);
        chk(cpu_irq, 1'b0);
        rdchk(B3, 32'h24);
        apb(1'b1, B0, 32'hA0);
        pulse;
        look(2);
        chk(cpu_irq, 1'b1);
        $display("test timer done");
        apb(1'b1, B0, 32'h90);
        ext <= 1'b1;
        look(8);
        chk(cpu_irq, 1'b1);
        rdchk(B0, 32'h92);
        apb(1'b1, B0, 32'h82);
        look(2);
        chk(cpu_irq, 1'b0);
        apb(1'b1, CFG, 32'h0);
        apb(1'b1, B0, 32'h90);
        ext <= 1'b0;
        look(8);
        rdchk(B0, 32'h92);
        apb(1'b1, B0, 32'h90);
        ext <= 1'b1;
        look(8);
        rdchk(B0, 32'h90);
        $display("test pin done");
        apb(1'b1, PCE, 32'h01);
        apb(1'b1, B0, 32'h88);
        pb <= 8'h80;
        look(8);
        rdchk(B0, 32'h88);
        pb <= 8'h81;
        look(8);
        chk(cpu_irq, 1'b1);
        apb(1'b1, B0, 32'h81);
        look(2);
        chk(cpu_irq, 1'b0);
        $display("test port done");
        @(posedge clk);
        pf <= 8'h01;
        apb(1'b1, PIE, 32'h01);
        apb(1'b1, B0, 32'h80);
        look(2);
        chk(cpu_irq, 1'b0);
        apb(1'b1, B0, 32'hC0);
        look(2);
        chk(cpu_irq, 1'b1);
        apb(1'b1, PIE, 32'h02);
        look(2);
        chk(cpu_irq, 1'b0);
        $display("test peripheral done");
        rdchk(STS, 32'h0F);
        look(0);
        chk(irq, 1'b0);
        apb(1'b1, MSK, 32'h01);
        look(2);
        chk(irq, 1'b1);
        apb(1'b1, STS, 32'h0F);
        look(2);
        chk(irq, 1'b0);
        rdchk(STS, 32'h00);
        pulse;
        look(3);
        chk(irq, 1'b1);
        $display("test events done");
        // Reset in mid-run with the pin still high: one edge follows release
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        look(0);
        chk(cpu_irq, 1'b0);
        chk(irq, 1'b0);
        rdchk(CFG, 32'h1);
        look(8);
        rdchk(B0, 32'h02);
        $display("test reset again done");
        print_verdict;
    end
endmodule
`default_nettype wire
